// ==== hw/trace_arm_ctrl.sv ====
// Functional notes
// - A trace starts only on a start command: emulation start for the emulation analyzer, external for external.
// - When linked, a separate external start is refused and one emulation start launches both analyzers.
// - Each arm source is line A asserted, line B asserted, or always armed.
// - The armed state is offered as a term to trigger, sequencer branch, count and prestore logic.
// - When linked, an external-only arm setting is refused and the emulation setting governs both.
// - After reset or analyzer init the arm selection is always armed and it can be read back.
// - With equal sense, assertion of the chosen line arms the analyzer.
// - With not-equal sense, a line set at start keeps the analyzer unarmed for the trace, else it arms at once.
// - Cross-trigger lines can be driven by the own trigger, the coax input and the coordinated measurement bus.
// - The activity monitor reports each input line as low, high or moving.
// - Activity is reported per pod of 16 lines with bit 0 lowest and bit 15 highest.
// - With the external analyzer in timing mode only equal-sense and always-armed arm selections are accepted.
`timescale 1ns/100ps
module trace_arm_ctrl (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EMU_TRIG_FOUND,
	input wire logic COAX_IN,
	input wire logic CMB_TRIG_IN,
	input wire logic [63:0] INPUT_LINES,
	output logic CROSS_TRIGGER_A,
	output logic CROSS_TRIGGER_B,
	output logic EMU_START,
	output logic EXT_START,
	output logic EMU_RUN,
	output logic EXT_RUN,
	output logic EMU_ARMED,
	output logic EXT_ARMED
);
	logic [1:0] ctrl_reg;
	logic [2:0] emu_sel_reg, ext_sel_reg;
	logic [5:0] route_reg;
	logic [31:0] prdata_reg, rd_next;
	logic pready_reg, pslverr_reg, err_next;
	logic emu_start_reg, ext_start_reg, emu_run_reg, ext_run_reg;
	logic emu_armed_reg, ext_armed_reg;
	logic line_a_reg, line_b_reg;
	logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_filt_reg;
	logic [1:0] pin_agree, pin_filt_next;
	logic [2:0] srcs;
	logic line_a_next, line_b_next;

	logic setup, access_ok, wr_en;
	logic hit_ctrl;
	logic hit_emu_arm;
	logic hit_ext_arm;
	logic hit_cmd;
	logic hit_status;
	logic hit_route;
	logic hit_act;
	logic hit_any;
	logic linked, timing;
	logic ext_arm_bad, cmd_bad, emu_arm_bad;
	logic cmd_wr;
	logic init_cmd;
	logic halt_cmd;
	logic mon_cmd;
	logic emu_go;
	logic ext_cmd_go;
	logic ext_go;
	logic [2:0] ext_eff_sel;
	logic emu_armed_w, ext_armed_w;
	logic [127:0] codes;
	logic [1:0] pod_idx;

	assign setup = PSEL && !PENABLE;
	assign access_ok = PSEL && PENABLE && pready_reg;
	assign wr_en = access_ok && PWRITE && !pslverr_reg;

	assign hit_ctrl = (PADDR == trace_arm_pkg::ADDR_CTRL);
	assign hit_emu_arm = (PADDR == trace_arm_pkg::ADDR_EMU_ARM);
	assign hit_ext_arm = (PADDR == trace_arm_pkg::ADDR_EXT_ARM);
	assign hit_cmd = (PADDR == trace_arm_pkg::ADDR_CMD);
	assign hit_status = (PADDR == trace_arm_pkg::ADDR_STATUS);
	assign hit_route = (PADDR == trace_arm_pkg::ADDR_ROUTE);
	assign hit_act = (PADDR[7:4] == trace_arm_pkg::ADDR_ACT_PAGE) && (PADDR[1:0] == 2'h0);
	assign hit_any = hit_ctrl || hit_emu_arm || hit_ext_arm || hit_cmd || hit_status || hit_route || hit_act;
	assign pod_idx = PADDR[trace_arm_pkg::POD_SEL_LSB +: 2];

	assign linked = ctrl_reg[trace_arm_pkg::CTRL_LINK_BIT];
	assign timing = ctrl_reg[trace_arm_pkg::CTRL_TIMING_BIT];

	// Refusals raise PSLVERR and leave all state untouched
	assign emu_arm_bad = !trace_arm_pkg::sel_legal(PWDATA[2:0]);
	assign ext_arm_bad = linked
		|| !trace_arm_pkg::sel_legal(PWDATA[2:0])
		|| (timing && trace_arm_pkg::sel_is_ne(PWDATA[2:0]));
	assign cmd_bad = linked && PWDATA[trace_arm_pkg::CMD_EXT_START_BIT];

	always_comb begin
		err_next = 1'b0;
		if (!hit_any) begin
			err_next = 1'b1;
		end else if (PWRITE && hit_emu_arm) begin
			err_next = emu_arm_bad;
		end else if (PWRITE && hit_ext_arm) begin
			err_next = ext_arm_bad;
		end else if (PWRITE && hit_cmd) begin
			err_next = cmd_bad;
		end else if (PWRITE && (hit_status || hit_act)) begin
			err_next = 1'b1;
		end
	end

	always_comb begin
		rd_next = '0;
		if (hit_ctrl) begin
			rd_next[1:0] = ctrl_reg;
		end else if (hit_emu_arm) begin
			rd_next[2:0] = emu_sel_reg;
		end else if (hit_ext_arm) begin
			rd_next[2:0] = ext_eff_sel;
		end else if (hit_status) begin
			rd_next[5:0] = {line_b_reg, line_a_reg, ext_armed_reg, emu_armed_reg, ext_run_reg, emu_run_reg};
		end else if (hit_route) begin
			rd_next[5:0] = route_reg;
		end else if (hit_act) begin
			rd_next = codes[32*pod_idx +: 32];
		end
	end

	assign cmd_wr = wr_en && hit_cmd;
	assign init_cmd = cmd_wr && PWDATA[trace_arm_pkg::CMD_INIT_BIT];
	assign halt_cmd = cmd_wr && PWDATA[trace_arm_pkg::CMD_HALT_BIT];
	assign mon_cmd = cmd_wr && PWDATA[trace_arm_pkg::CMD_MON_BIT];
	// Init overrides a start written in the same word
	assign emu_go = cmd_wr && PWDATA[trace_arm_pkg::CMD_EMU_START_BIT] && !init_cmd;
	assign ext_cmd_go = cmd_wr && PWDATA[trace_arm_pkg::CMD_EXT_START_BIT] && !init_cmd;
	assign ext_go = linked ? emu_go : ext_cmd_go;
	assign ext_eff_sel = linked ? emu_sel_reg : ext_sel_reg;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup ? err_next : 1'b0;
			prdata_reg <= (setup && !PWRITE) ? rd_next : '0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= '0;
			route_reg <= trace_arm_pkg::ROUTE_RESET;
		end else if (wr_en && hit_ctrl) begin
			ctrl_reg <= PWDATA[1:0];
		end else if (wr_en && hit_route) begin
			route_reg <= PWDATA[5:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			emu_sel_reg <= trace_arm_pkg::ARM_ALWAYS;
			ext_sel_reg <= trace_arm_pkg::ARM_ALWAYS;
		end else if (init_cmd) begin
			emu_sel_reg <= trace_arm_pkg::ARM_ALWAYS;
			ext_sel_reg <= trace_arm_pkg::ARM_ALWAYS;
		end else if (wr_en && hit_emu_arm) begin
			emu_sel_reg <= PWDATA[2:0];
		end else if (wr_en && hit_ext_arm) begin
			ext_sel_reg <= PWDATA[2:0];
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			emu_start_reg <= 1'b0;
			ext_start_reg <= 1'b0;
			emu_run_reg <= 1'b0;
			ext_run_reg <= 1'b0;
		end else begin
			emu_start_reg <= emu_go;
			ext_start_reg <= ext_go;
			emu_run_reg <= emu_go || (emu_run_reg && !halt_cmd && !init_cmd);
			ext_run_reg <= ext_go || (ext_run_reg && !halt_cmd && !init_cmd);
		end
	end

	// Pins from outside: three stages, change taken when stages two and three agree
	assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
	assign pin_filt_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_filt_reg);
	assign srcs = {pin_filt_reg[1], pin_filt_reg[0], EMU_TRIG_FOUND};
	assign line_a_next = |(srcs & route_reg[trace_arm_pkg::ROUTE_A_LSB +: trace_arm_pkg::ROUTE_W]);
	assign line_b_next = |(srcs & route_reg[trace_arm_pkg::ROUTE_B_LSB +: trace_arm_pkg::ROUTE_W]);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			pin_filt_reg <= '0;
			line_a_reg <= 1'b0;
			line_b_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {CMB_TRIG_IN, COAX_IN};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_filt_reg <= pin_filt_next;
			line_a_reg <= line_a_next;
			line_b_reg <= line_b_next;
		end
	end

	arm_unit emu_arm (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.start(emu_go),
		.halt(halt_cmd || init_cmd),
		.sel(emu_sel_reg),
		.line_a(line_a_reg),
		.line_b(line_b_reg),
		.armed(emu_armed_w)
	);

	arm_unit ext_arm (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.start(ext_go),
		.halt(halt_cmd || init_cmd),
		.sel(ext_eff_sel),
		.line_a(line_a_reg),
		.line_b(line_b_reg),
		.armed(ext_armed_w)
	);

	activity_monitor monitor (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.lines(INPUT_LINES),
		.clear(mon_cmd),
		.codes(codes)
	);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			emu_armed_reg <= 1'b0;
			ext_armed_reg <= 1'b0;
		end else begin
			emu_armed_reg <= emu_armed_w;
			ext_armed_reg <= ext_armed_w;
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign CROSS_TRIGGER_A = line_a_reg;
	assign CROSS_TRIGGER_B = line_b_reg;
	assign EMU_START = emu_start_reg;
	assign EXT_START = ext_start_reg;
	assign EMU_RUN = emu_run_reg;
	assign EXT_RUN = ext_run_reg;
	assign EMU_ARMED = emu_armed_reg;
	assign EXT_ARMED = ext_armed_reg;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_ext_arm_setup_linked;
		setup && PWRITE && hit_ext_arm && linked;
	endsequence

	sequence s_emu_arm_write_ok;
		setup && PWRITE && hit_emu_arm && !emu_arm_bad;
	endsequence

	sequence s_ext_arm_read_linked;
		setup && !PWRITE && hit_ext_arm && linked;
	endsequence

	sequence s_timing_eq_write;
		setup && PWRITE && hit_ext_arm && !linked && timing
			&& trace_arm_pkg::sel_legal(PWDATA[2:0]) && !trace_arm_pkg::sel_is_ne(PWDATA[2:0]);
	endsequence

	chk_start_cause: assert property (EMU_START |-> $past(cmd_wr) && $past(PWDATA[trace_arm_pkg::CMD_EMU_START_BIT]))
		else $error("Emulation start without a start command");
	chk_linked_start: assert property (linked && emu_go |=> EXT_START && EMU_START)
		else $error("Linked emulation start did not start both");
	chk_linked_ext_refused: assert property (setup && PWRITE && hit_cmd && cmd_bad |=> PSLVERR ##1 !EXT_START)
		else $error("Separate external start accepted while linked");
	chk_sel_legal: assert property (trace_arm_pkg::sel_legal(emu_sel_reg) && trace_arm_pkg::sel_legal(ext_sel_reg))
		else $error("Arm selection holds an illegal code");
	chk_armed_running: assert property (EMU_ARMED |-> EMU_RUN || $past(halt_cmd || init_cmd))
		else $error("Armed term set with no trace running");
	chk_linked_arm_kept: assert property (s_ext_arm_setup_linked |=> PSLVERR ##1 $stable(ext_sel_reg))
		else $error("External arm setting changed while linked");
	chk_init_default: assert property (init_cmd |=> emu_sel_reg == trace_arm_pkg::ARM_ALWAYS && ext_sel_reg == trace_arm_pkg::ARM_ALWAYS)
		else $error("Init did not restore always-armed selection");
	chk_timing_ne: assert property (setup && PWRITE && hit_ext_arm && timing && trace_arm_pkg::sel_is_ne(PWDATA[2:0]) |=> PSLVERR)
		else $error("Not-equal arm accepted in timing mode");
	chk_cross_route: assert property (route_reg[trace_arm_pkg::ROUTE_A_LSB] && EMU_TRIG_FOUND |=> CROSS_TRIGGER_A)
		else $error("Own trigger did not drive cross line A");
	chk_pin_latency: assert property ($rose(COAX_IN) ##1 $stable(COAX_IN) [*3] ##1 route_reg[trace_arm_pkg::ROUTE_B_LSB + 1]
		|=> CROSS_TRIGGER_B)
		else $error("Coax pin not seen on line B after sync delay");

	chk_ext_start_cause: assert property (EXT_START |-> $past(cmd_wr)
		&& ($past(PWDATA[trace_arm_pkg::CMD_EXT_START_BIT])
		|| ($past(linked) && $past(PWDATA[trace_arm_pkg::CMD_EMU_START_BIT]))))
		else $error("External start without a matching start command");
	chk_emu_idle: assert property (!emu_go && !EMU_RUN |=> !EMU_RUN)
		else $error("Emulation trace ran without a start");
	chk_ext_idle: assert property (!ext_go && !EXT_RUN |=> !EXT_RUN)
		else $error("External trace ran without a start");
	chk_start_runs: assert property (emu_go |=> EMU_RUN && EMU_START)
		else $error("Emulation start did not launch a trace");
	chk_init_stops: assert property (init_cmd |=> !EMU_RUN && !EXT_RUN)
		else $error("Init left a trace running");

	chk_illegal_refused: assert property (setup && PWRITE && (hit_emu_arm || hit_ext_arm)
		&& !trace_arm_pkg::sel_legal(PWDATA[2:0]) |=> PSLVERR)
		else $error("Illegal arm code accepted");
	chk_emu_arm_write: assert property (s_emu_arm_write_ok |=> ##1 emu_sel_reg == $past(PWDATA[2:0]))
		else $error("Accepted arm setting not stored");
	chk_emu_armed_always: assert property (emu_go && emu_sel_reg == trace_arm_pkg::ARM_ALWAYS
		|=> ##1 EMU_ARMED)
		else $error("Always-armed emulation start did not arm");
	chk_ext_armed_always: assert property (ext_go && ext_eff_sel == trace_arm_pkg::ARM_ALWAYS
		|=> ##1 EXT_ARMED)
		else $error("Always-armed external start did not arm");
	chk_armed_term: assert property (EMU_ARMED == $past(emu_armed_w) && EXT_ARMED == $past(ext_armed_w))
		else $error("Armed term does not follow arm units");
	chk_linked_read: assert property (s_ext_arm_read_linked |=> PRDATA[2:0] == $past(emu_sel_reg))
		else $error("Linked external arm read does not show emulation setting");
	chk_emu_sel_read: assert property (setup && !PWRITE && hit_emu_arm |=> PRDATA[2:0] == $past(emu_sel_reg))
		else $error("Arm selection read back wrong");
	chk_timing_eq_ok: assert property (s_timing_eq_write |=> !PSLVERR)
		else $error("Equal-sense arm refused in timing mode");
	chk_route_b: assert property (route_reg[trace_arm_pkg::ROUTE_B_LSB] && EMU_TRIG_FOUND |=> CROSS_TRIGGER_B)
		else $error("Own trigger did not drive cross line B");
	chk_unrouted_quiet: assert property (route_reg == '0 |=> !CROSS_TRIGGER_A && !CROSS_TRIGGER_B)
		else $error("Cross line driven with no source routed");
endmodule : trace_arm_ctrl

// ==== hw/trace_arm_pkg.sv ====
package trace_arm_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EMU_ARM = 8'h04;
	localparam logic [7:0] ADDR_EXT_ARM = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_ROUTE = 8'h14;
	localparam logic [3:0] ADDR_ACT_PAGE = 4'h2;
	localparam int CTRL_LINK_BIT = 0;
	localparam int CTRL_TIMING_BIT = 1;
	localparam int CMD_EMU_START_BIT = 0;
	localparam int CMD_EXT_START_BIT = 1;
	localparam int CMD_INIT_BIT = 2;
	localparam int CMD_MON_BIT = 3;
	localparam int CMD_HALT_BIT = 4;
	localparam int ROUTE_W = 3;
	localparam int ROUTE_A_LSB = 0;
	localparam int ROUTE_B_LSB = 3;
	localparam logic [5:0] ROUTE_RESET = 6'h00;
	localparam int POD_W = 16;
	localparam int NUM_PODS = 4;
	localparam int LINES = POD_W * NUM_PODS;
	localparam int POD_SEL_LSB = 2;
	localparam int ARM_SEL_W = 3;
	localparam logic [1:0] ACT_LOW = 2'h0;
	localparam logic [1:0] ACT_HIGH = 2'h1;
	localparam logic [1:0] ACT_MOVING = 2'h2;

	typedef enum logic [2:0] {
		ARM_ALWAYS = 3'h0,
		ARM_EQ_A = 3'h1,
		ARM_EQ_B = 3'h2,
		ARM_NE_A = 3'h3,
		ARM_NE_B = 3'h4
	} arm_sel_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_ARMED = 4'h4,
		ST_BLOCKED = 4'h8
	} arm_state_e;

	function automatic logic sel_legal(input logic [2:0] s);
		sel_legal = (s <= ARM_NE_B);
	endfunction : sel_legal

	function automatic logic sel_is_ne(input logic [2:0] s);
		sel_is_ne = (s == ARM_NE_A) || (s == ARM_NE_B);
	endfunction : sel_is_ne

	function automatic logic sel_line(input logic [2:0] s, input logic a, input logic b);
		sel_line = ((s == ARM_EQ_A) || (s == ARM_NE_A)) ? a : b;
	endfunction : sel_line
endpackage : trace_arm_pkg

// ==== hw/arm_unit.sv ====
`timescale 1ns/100ps
module arm_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic halt,
	input wire logic [2:0] sel,
	input wire logic line_a,
	input wire logic line_b,
	output logic armed
);
	trace_arm_pkg::arm_state_e state_reg, state_next;
	logic line_now;
	logic always_sel;
	logic ne_sel;

	assign line_now = trace_arm_pkg::sel_line(sel, line_a, line_b);
	assign always_sel = (sel == trace_arm_pkg::ARM_ALWAYS);
	assign ne_sel = trace_arm_pkg::sel_is_ne(sel);
	assign armed = (state_reg == trace_arm_pkg::ST_ARMED);

	always_comb begin
		state_next = state_reg;
		// Start wins over halt in one command word, so run and armed agree
		if (start) begin
			if (always_sel) begin
				state_next = trace_arm_pkg::ST_ARMED;
			end else if (ne_sel) begin
				// Line captured once at start decides the whole trace
				state_next = line_now ? trace_arm_pkg::ST_BLOCKED : trace_arm_pkg::ST_ARMED;
			end else begin
				state_next = line_now ? trace_arm_pkg::ST_ARMED : trace_arm_pkg::ST_WAIT;
			end
		end else if (halt) begin
			state_next = trace_arm_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				trace_arm_pkg::ST_WAIT: begin
					if (line_now) begin
						state_next = trace_arm_pkg::ST_ARMED;
					end
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= trace_arm_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_ne_start_hit;
		start && !halt && ne_sel && line_now;
	endsequence

	chk_eq_arms: assert property (state_reg == trace_arm_pkg::ST_WAIT && line_now && !start && !halt |=> armed)
		else $error("Equal-sense line did not arm");
	chk_ne_blocked: assert property (s_ne_start_hit ##1 (!start && !halt) [*2] |-> !armed)
		else $error("Not-equal arm armed though line was set at start");
	chk_ne_clear_arms: assert property (start && !halt && ne_sel && !line_now |=> armed)
		else $error("Not-equal arm failed to arm at once");
	chk_armed_holds: assert property (armed && !start && !halt |=> armed)
		else $error("Armed state dropped before next start");
endmodule : arm_unit

// ==== hw/activity_monitor.sv ====
`timescale 1ns/100ps
module activity_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [63:0] lines,
	input wire logic clear,
	output logic [127:0] codes
);
	logic [63:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic [63:0] seen_hi_reg, seen_lo_reg, seen_hi_next, seen_lo_next;
	logic [127:0] codes_reg, codes_next;
	logic [63:0] agree;

	assign agree = ~(s2_reg ^ s3_reg);
	assign filt_next = (agree & s3_reg) | (~agree & filt_reg);
	assign seen_hi_next = clear ? filt_reg : (seen_hi_reg | filt_reg);
	assign seen_lo_next = clear ? ~filt_reg : (seen_lo_reg | ~filt_reg);
	assign codes = codes_reg;

	always_comb begin
		codes_next = '0;
		for (int i = 0; i < 64; i++) begin
			if (seen_hi_reg[i] && seen_lo_reg[i]) begin
				codes_next[2*i +: 2] = trace_arm_pkg::ACT_MOVING;
			end else if (seen_hi_reg[i]) begin
				codes_next[2*i +: 2] = trace_arm_pkg::ACT_HIGH;
			end else begin
				codes_next[2*i +: 2] = trace_arm_pkg::ACT_LOW;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
			seen_hi_reg <= '0;
			seen_lo_reg <= '0;
			codes_reg <= '0;
		end else begin
			s1_reg <= lines;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			seen_hi_reg <= seen_hi_next;
			seen_lo_reg <= seen_lo_next;
			codes_reg <= codes_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_toggle_code: assert property (seen_hi_reg[0] && seen_lo_reg[0] |=> codes_reg[1:0] == trace_arm_pkg::ACT_MOVING)
		else $error("Toggling line 0 not reported as moving");
	chk_msb_code: assert property (seen_hi_reg[15] && !seen_lo_reg[15] |=> codes_reg[31:30] == trace_arm_pkg::ACT_HIGH)
		else $error("Steady high line 15 not in top field of pod");
endmodule : activity_monitor

// ==== test/line_driver.sv ====
`timescale 1ns/100ps
module line_driver (
	input wire logic clk,
	input wire logic [63:0] level,
	input wire logic [63:0] toggle_mask,
	output logic [63:0] lines
);
	logic [1:0] phase_reg = 2'h0;

	// Masked lines hold each level two cycles, long enough for the pin filter to accept it
	always @(posedge clk) begin
		phase_reg <= phase_reg + 2'h1;
	end

	assign lines = level ^ (toggle_mask & {64{phase_reg[1]}});
endmodule : line_driver

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic trig, coax, coordinated_measurement_bus, xa, xb, emu_st, ext_st, emu_run, ext_run, emu_armed, ext_armed;
	logic [63:0] level, tmask, lines;
	int miscompares = 0;
	int comparisons = 0;
	int emu_n = 0;
	int ext_n = 0;
	int both_n = 0;

	trace_arm_ctrl dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EMU_TRIG_FOUND(trig), .COAX_IN(coax), .CMB_TRIG_IN(coordinated_measurement_bus), .INPUT_LINES(lines),
		.CROSS_TRIGGER_A(xa), .CROSS_TRIGGER_B(xb), .EMU_START(emu_st), .EXT_START(ext_st),
		.EMU_RUN(emu_run), .EXT_RUN(ext_run), .EMU_ARMED(emu_armed), .EXT_ARMED(ext_armed));
	line_driver pods (.clk(clk), .level(level), .toggle_mask(tmask), .lines(lines));

	always @(posedge clk) begin
		if (emu_st === 1'b1) emu_n++;
		if (ext_st === 1'b1) ext_n++;
		if (emu_st === 1'b1 && ext_st === 1'b1) both_n++;
	end

	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input string what, input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, rd, err);
		check(what, {31'h0, err}, {31'h0, e});
	endtask : wr

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 32'h0, rd, err);
		check(what, rd, e);
		check("read refused", {31'h0, err}, 32'h0);
	endtask : rdc

	task automatic t_reset();
		logic [31:0] rd;
		logic err;
		rdc("emu arm", trace_arm_pkg::ADDR_EMU_ARM, 32'h0);
		rdc("ext arm", trace_arm_pkg::ADDR_EXT_ARM, 32'h0);
		rdc("cmd", trace_arm_pkg::ADDR_CMD, 32'h0);
		apb(1'b0, 8'h40, 32'h0, rd, err);
		check("unmapped", {31'h0, err}, 32'h1);
		wr("status write", trace_arm_pkg::ADDR_STATUS, 32'h3F, 1'b1);
		check("idle run", {30'h0, emu_run, ext_run}, 32'h0);
		check("no starts", emu_n + ext_n, 32'h0);
	endtask : t_reset

	task automatic t_ext_start();
		wr("ext start", trace_arm_pkg::ADDR_CMD, 32'h2, 1'b0);
		cyc(3);
		check("ext pulse", ext_n, 32'h1);
		check("emu pulse", emu_n, 32'h0);
		check("ext run", {31'h0, ext_run}, 32'h1);
		check("ext armed", {31'h0, ext_armed}, 32'h1);
	endtask : t_ext_start

	task automatic t_eq_arm();
		logic [31:0] rd;
		logic err;
		int n;
		wr("route", trace_arm_pkg::ADDR_ROUTE, 32'h02, 1'b0);
		wr("arm eq a", trace_arm_pkg::ADDR_EMU_ARM, 32'h1, 1'b0);
		wr("start", trace_arm_pkg::ADDR_CMD, 32'h1, 1'b0);
		cyc(4);
		check("not armed yet", {31'h0, emu_armed}, 32'h0);
		check("emu run", {31'h0, emu_run}, 32'h1);
		coax <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, trace_arm_pkg::ADDR_STATUS, 32'h0, rd, err);
			n++;
		end while (rd[2] !== 1'b1 && n < 10);
		check("armed by line", {31'h0, rd[2]}, 32'h1);
		check("line a", {31'h0, rd[4]}, 32'h1);
		coax <= 1'b0;
		cyc(10);
		check("armed holds", {31'h0, emu_armed}, 32'h1);
	endtask : t_eq_arm

	task automatic t_ne_arm();
		coax <= 1'b1;
		cyc(8);
		wr("arm ne a", trace_arm_pkg::ADDR_EMU_ARM, 32'h3, 1'b0);
		wr("start", trace_arm_pkg::ADDR_CMD, 32'h1, 1'b0);
		cyc(4);
		coax <= 1'b0;
		cyc(10);
		check("blocked", {31'h0, emu_armed}, 32'h0);
		wr("restart", trace_arm_pkg::ADDR_CMD, 32'h1, 1'b0);
		cyc(3);
		check("armed at once", {31'h0, emu_armed}, 32'h1);
	endtask : t_ne_arm

	task automatic t_link();
		int e0;
		int x0;
		int b0;
		wr("link", trace_arm_pkg::ADDR_CTRL, 32'h1, 1'b0);
		x0 = ext_n;
		wr("linked ext start", trace_arm_pkg::ADDR_CMD, 32'h3, 1'b1);
		wr("linked ext arm", trace_arm_pkg::ADDR_EXT_ARM, 32'h1, 1'b1);
		wr("arm eq b", trace_arm_pkg::ADDR_EMU_ARM, 32'h2, 1'b0);
		rdc("ext follows emu", trace_arm_pkg::ADDR_EXT_ARM, 32'h2);
		check("refused start", ext_n - x0, 32'h0);
		e0 = emu_n;
		x0 = ext_n;
		b0 = both_n;
		wr("linked start", trace_arm_pkg::ADDR_CMD, 32'h1, 1'b0);
		cyc(3);
		check("emu pulse", emu_n - e0, 32'h1);
		check("joint pulse", both_n - b0, 32'h1);
		check("ext pulse", ext_n - x0, 32'h1);
		wr("unlink", trace_arm_pkg::ADDR_CTRL, 32'h0, 1'b0);
	endtask : t_link

	task automatic t_timing();
		wr("timing", trace_arm_pkg::ADDR_CTRL, 32'h2, 1'b0);
		for (int c = 0; c < 6; c++) begin
			wr("timing ext arm", trace_arm_pkg::ADDR_EXT_ARM, c, c >= 3);
		end
		rdc("ext arm kept", trace_arm_pkg::ADDR_EXT_ARM, 32'h2);
		wr("state mode", trace_arm_pkg::ADDR_CTRL, 32'h0, 1'b0);
		wr("ext ne b", trace_arm_pkg::ADDR_EXT_ARM, 32'h4, 1'b0);
		wr("init", trace_arm_pkg::ADDR_CMD, 32'h4, 1'b0);
		rdc("emu arm init", trace_arm_pkg::ADDR_EMU_ARM, 32'h0);
		rdc("ext arm init", trace_arm_pkg::ADDR_EXT_ARM, 32'h0);
	endtask : t_timing

	task automatic t_route();
		wr("route", trace_arm_pkg::ADDR_ROUTE, 32'h1D, 1'b0);
		rdc("route back", trace_arm_pkg::ADDR_ROUTE, 32'h1D);
		coordinated_measurement_bus <= 1'b1;
		cyc(10);
		check("a from bus", {30'h0, xa, xb}, 32'h2);
		coax <= 1'b1;
		cyc(4);
		check("coax sync delay", {30'h0, xa, xb}, 32'h2);
		cyc(2);
		check("b from coax", {30'h0, xa, xb}, 32'h3);
		coax <= 1'b0;
		cyc(8);
		check("coax released", {30'h0, xa, xb}, 32'h2);
		trig <= 1'b1;
		cyc(4);
		check("b from trigger", {30'h0, xa, xb}, 32'h3);
		coordinated_measurement_bus <= 1'b0;
		trig <= 1'b0;
	endtask : t_route

	task automatic t_monitor();
		level <= 64'h0000_0000_0001_8000;
		tmask <= 64'h0000_0000_0000_0001;
		cyc(8);
		wr("clear history", trace_arm_pkg::ADDR_CMD, 32'h8, 1'b0);
		cyc(10);
		rdc("pod0", {trace_arm_pkg::ADDR_ACT_PAGE, 4'h0}, 32'h4000_0002);
		rdc("pod1", {trace_arm_pkg::ADDR_ACT_PAGE, 4'h4}, 32'h0000_0001);
		rdc("pod2", {trace_arm_pkg::ADDR_ACT_PAGE, 4'h8}, 32'h0000_0000);
		wr("act write", {trace_arm_pkg::ADDR_ACT_PAGE, 4'h0}, 32'h0, 1'b1);
	endtask : t_monitor

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		wrap_up();
	end

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, trig, coax, coordinated_measurement_bus} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		level = 64'h0;
		tmask = 64'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		t_reset();
		t_ext_start();
		t_eq_arm();
		t_ne_arm();
		t_link();
		t_timing();
		t_route();
		t_monitor();
		wrap_up();
	end
endmodule : tb_top
